// File: src/sep_eeprom_slave.sv
`timescale 1ns/1ps
module sep_eeprom_slave
  import sep_pkg::*;
#(
  parameter int         PROG_CYC   = PROG_CYCLES,
  parameter bit         HAS_STRAPS = 1'b1,
  // device-type code; value is arbitrary
  parameter logic [3:0] DEV_TYPE   = 4'h5
) (
  // clock, reset, enable
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ce,
  // two-wire bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n,
  // straps and protect
  input  wire logic addr_select_bit0,
  input  wire logic addr_select_bit1,
  input  wire logic addr_select_bit2,
  input  wire logic wp,
  // status
  output logic      prog_busy
);
  localparam int CW = $clog2(PROG_CYC);

  if (PROG_CYC < 2 * PAGE_BYTES + FIFO_DEPTH) begin : g_chk
    $error("sep_eeprom_slave: programming count too short for commit");
  end

  typedef struct packed {
    logic [5:0]          s1;
    logic [5:0]          s2;
    logic [5:0]          s3;
    logic [5:0]          filt;
    sep_state_t          st;
    sep_kind_t           kind;
    logic [3:0]          bcnt;
    logic [7:0]          sh;
    logic                rw;
    logic                ack;
    logic [MEM_AW-1:0]   addr;
    logic                wp_lat;
    logic                loaded;
    logic                busy;
    logic                wstart;
    logic                wdone;
    logic [CW-1:0]       pcnt;
    logic [PAGE_AW-1:0]  wptr;
    logic [PAGE_BYTES-1:0] mask;
    logic                oe_n;
  } sep_core_t;

  localparam sep_core_t RST_VAL = '{
    s1: PIN_RST, s2: PIN_RST, s3: PIN_RST, filt: PIN_RST,
    st: ST_IDLE, kind: BK_DEV, bcnt: 4'h0, sh: 8'h00, rw: 1'b0, ack: 1'b0,
    addr: '0, wp_lat: 1'b0, loaded: 1'b0, busy: 1'b0, wstart: 1'b0,
    wdone: 1'b0, pcnt: '0, wptr: '0, mask: '0, oe_n: 1'b1
  };

  sep_core_t          r;
  sep_core_t          n;
  logic [7:0]         mem  [1 << MEM_AW] = '{default: ERASED}; // R19
  logic [7:0]         pbuf [PAGE_BYTES];
  logic [5:0]         pins;
  logic [5:0]         fnew;
  logic [2:0]         sel;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_ev;
  logic               stop_ev;
  logic               match;
  logic               decide;
  logic               push;
  logic               fifo_in_ready;
  logic               fifo_ovalid;
  logic               fifo_oready;
  logic [FIFO_W-1:0]  fifo_odata;
  logic               mem_we;
  logic [MEM_AW-1:0]  mem_wa;
  logic [7:0]         rd_byte;

  assign pins = {addr_select_bit2, addr_select_bit1, addr_select_bit0, wp, sda_i, scl_i};
  // filtered level moves only once stages two and three agree
  assign fnew     = (r.s2 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
  assign scl_rise = ~r.filt[PIN_SCL] & fnew[PIN_SCL];
  assign scl_fall = r.filt[PIN_SCL] & ~fnew[PIN_SCL];
  assign start_ev = r.filt[PIN_SCL] & fnew[PIN_SCL] & r.filt[PIN_SDA] & ~fnew[PIN_SDA]; // R06
  assign stop_ev  = r.filt[PIN_SCL] & fnew[PIN_SCL] & ~r.filt[PIN_SDA] & fnew[PIN_SDA]; // R06
  assign sel      = HAS_STRAPS ? r.filt[PIN_SEL0+2:PIN_SEL0] : 3'h0; // R04
  assign match    = (r.sh[7:4] == DEV_TYPE) && (r.sh[3:1] == sel) && !r.busy; // R03 R11 R26
  assign decide   = (r.st == ST_RX) && scl_fall && (r.bcnt == BIT_LAST);
  assign push     = decide && (r.kind == BK_DATA) && !r.wp_lat && fifo_in_ready;
  assign rd_byte  = mem[r.addr];
  assign mem_wa   = {r.addr[MEM_AW-1:PAGE_AW], r.wptr};
  // drain stalls from the start of the array write until the programming period ends
  assign fifo_oready = !(r.busy && r.wstart);
  assign sda_o     = 1'b0; // R02
  assign sda_oe_n  = r.oe_n;
  assign prog_busy = r.busy;

  sep_fifo #(
    .W (FIFO_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .en        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({r.addr[PAGE_AW-1:0], r.sh}),
    .out_valid (fifo_ovalid),
    .out_ready (fifo_oready),
    .out_data  (fifo_odata)
  );

  always_comb begin
    n = r;
    mem_we = 1'b0;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.filt = fnew;
    unique case (r.st)
      ST_IDLE: begin
        n.oe_n = 1'b1; // R07
      end
      ST_RX: begin
        if (scl_rise && r.bcnt != BIT_LAST) begin
          n.sh = {r.sh[6:0], fnew[PIN_SDA]}; // R02
          n.bcnt = r.bcnt + 4'h1;
        end
        if (decide) begin
          n.st = ST_RACK;
          unique case (r.kind)
            BK_DEV: begin
              n.ack = match;
              n.rw = r.sh[0]; // R05
            end
            BK_AHI: begin
              n.ack = 1'b1; // R10
              n.addr[MEM_AW-1:8] = r.sh[MEM_AW-9:0]; // R25
            end
            BK_ALO: begin
              n.ack = 1'b1; // R10
              n.addr[7:0] = r.sh;
            end
            BK_DATA: begin
              n.ack = push; // R18
              if (push) begin
                n.loaded = 1'b1; // R12
                n.addr[PAGE_AW-1:0] = r.addr[PAGE_AW-1:0] + 1'b1; // R13
              end
            end
          endcase
          n.oe_n = !n.ack; // R09
        end
      end
      ST_RACK: begin
        if (scl_fall) begin
          n.oe_n = 1'b1;
          n.bcnt = 4'h0;
          if (!r.ack) begin
            n.st = ST_IDLE;
          end else if (r.kind == BK_DEV && r.rw) begin
            n.st = ST_TX; // R20
            n.sh = rd_byte;
            n.oe_n = rd_byte[7]; // R02
          end else begin
            n.st = ST_RX;
            unique case (r.kind)
              BK_DEV:  n.kind = BK_AHI;
              BK_AHI:  n.kind = BK_ALO;
              BK_ALO: begin
                n.kind = BK_DATA;
                n.wp_lat = r.filt[PIN_WP]; // R17
              end
              BK_DATA: n.kind = BK_DATA;
            endcase
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          if (r.bcnt == TX_LAST) begin
            n.st = ST_TACK;
            n.oe_n = 1'b1; // R09
            n.addr = r.addr + 1'b1; // R24 R25
          end else begin
            n.sh = {r.sh[6:0], 1'b0};
            n.oe_n = r.sh[6];
            n.bcnt = r.bcnt + 4'h1;
          end
        end
      end
      ST_TACK: begin
        if (scl_rise) begin
          n.ack = !fnew[PIN_SDA];
        end
        if (scl_fall) begin
          if (r.ack) begin
            n.st = ST_TX; // R23
            n.sh = rd_byte;
            n.oe_n = rd_byte[7];
            n.bcnt = 4'h0;
          end else begin
            n.st = ST_IDLE; // R21
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
        n.oe_n = 1'b1;
      end
    endcase
    if (start_ev) begin
      n.st = ST_RX; // R06 R22
      n.kind = BK_DEV;
      n.bcnt = 4'h0;
      n.oe_n = 1'b1;
    end else if (stop_ev) begin
      n.st = ST_IDLE; // R06
      n.oe_n = 1'b1;
      if (r.loaded && !r.busy) begin
        n.busy = 1'b1; // R11 R15
        n.pcnt = '0;
      end
    end
    if (fifo_ovalid && fifo_oready) begin
      n.mask[fifo_odata[FIFO_W-1:8]] = 1'b1; // R14
    end
    if (r.busy) begin
      n.pcnt = r.pcnt + 1'b1;
      if (!r.wstart && !fifo_ovalid) begin
        n.wstart = 1'b1;
      end
      if (r.wstart && !r.wdone) begin
        mem_we = r.mask[r.wptr]; // R15
        n.wptr = r.wptr + 1'b1;
        if (r.wptr == PAGE_AW'(PAGE_BYTES - 1)) begin
          n.wdone = 1'b1;
        end
      end
      if (r.pcnt == CW'(PROG_CYC - 1)) begin
        n.busy = 1'b0; // R26
        n.loaded = 1'b0;
        n.wstart = 1'b0;
        n.wdone = 1'b0;
        n.wptr = '0;
        n.mask = '0;
        n.pcnt = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r <= RST_VAL; // R01
    end else if (ce) begin
      r <= n;
    end
  end

  // page buffer: a later byte for a slot overwrites the earlier one
  always_ff @(posedge ref_clk) begin
    if (ce && fifo_ovalid && fifo_oready) begin
      pbuf[fifo_odata[FIFO_W-1:8]] <= fifo_odata[7:0]; // R14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= pbuf[r.wptr];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_idle_released: assert property (r.st == ST_IDLE |-> sda_oe_n) // R07
    else $error("bus driven while idle");

  a_busy_addr_nack: assert property (
    ce && r.busy && decide && r.kind == BK_DEV |=> r.st == ST_RACK && sda_oe_n) // R11
    else $error("address acknowledged during programming");

  a_wp_rejects: assert property (
    ce && decide && r.kind == BK_DATA && r.wp_lat |=> sda_oe_n && !r.ack && !r.loaded) // R18
    else $error("protected write was accepted");

  a_page_latched: assert property (
    ce && push |=> r.addr[MEM_AW-1:PAGE_AW] == $past(r.addr[MEM_AW-1:PAGE_AW])
      && r.addr[PAGE_AW-1:0] == $past(r.addr[PAGE_AW-1:0]) + 1'b1) // R13
    else $error("page address moved during load");

  a_stop_ends: assert property (ce && stop_ev && !start_ev |=> r.st == ST_IDLE) // R06
    else $error("stop did not end command");

  a_commit_starts: assert property (
    ce && stop_ev && r.loaded && !r.busy |=> r.busy ##1 (r.busy [*8])) // R15
    else $error("programming did not start after stop");

  a_seq_incr: assert property (
    ce && r.st == ST_TX && scl_fall && r.bcnt == TX_LAST
      |=> r.st == ST_TACK && r.addr == $past(r.addr) + 1'b1) // R24
    else $error("read address did not advance");

  a_addr_match: assert property (
    ce && decide && r.kind == BK_DEV && !match |=> !r.ack ##0 sda_oe_n) // R03
    else $error("foreign address acknowledged");

  a_ack_driven: assert property (r.st == ST_RACK && r.ack |-> !sda_oe_n && !sda_o) // R09
    else $error("acknowledge not driven low");

  a_tx_after_fall: assert property (
    ce && $changed(sda_oe_n) && r.st == ST_TX |-> $past(scl_fall) || $past(r.st) != ST_TX) // R02
    else $error("output changed away from clock fall");

  a_rx_released: assert property (r.st == ST_RX |-> sda_oe_n) // R09
    else $error("bus driven while receiving");

  a_wp_strobe: assert property (
    ce && r.st == ST_RACK && r.kind == BK_ALO && r.ack && scl_fall
      |=> r.wp_lat == $past(r.filt[PIN_WP])) // R17
    else $error("protect level not taken at last fall");

  a_commit_done: assert property (r.busy && r.pcnt == CW'(PROG_CYC - 1) |-> r.wdone) // R15
    else $error("page not written before programming ended");

  a_busy_ends: assert property (
    ce && r.busy && r.pcnt == CW'(PROG_CYC - 1) |=> !prog_busy) // R26
    else $error("programming period overran");

  c_byte_commit:  cover property (stop_ev && r.loaded && !r.busy);
  c_read_ack:     cover property (r.st == ST_TACK && scl_fall && r.ack);
  c_wp_reject:    cover property (decide && r.kind == BK_DATA && r.wp_lat);
  c_busy_poll:    cover property (decide && r.kind == BK_DEV && r.busy);
  c_page_wrap:    cover property (push && r.addr[PAGE_AW-1:0] == '1);
endmodule // sep_eeprom_slave

// File: src/sep_pkg.sv
// Operation
// R01 - Reset puts the slave in standby; every reset restarts it cleanly.
// R02 - Data sampled on clock rise, driven after clock fall, only pulled low.
// R03 - Address byte: top four bits match type code, next three match straps.
// R04 - Variants without straps match only select bits of zero.
// R05 - Address byte bit zero selects read (one) or write (zero).
// R06 - Start is data falling with clock high; stop is data rising; stop ends commands.
// R07 - Nothing is driven and nothing acted on before a start.
// R08 - Master keeps data stable while clock high, starts only on idle bus.
// R09 - Ninth clock: sender releases data, receiver pulls low to acknowledge.
// R10 - Byte write: address, two address bytes, one data byte, stop; all acknowledged.
// R11 - Stop after loaded data starts programming; no address acknowledge until done.
// R12 - Data bytes fill a 32-byte page buffer from the given address.
// R13 - Page part latched; only byte-in-page increments and wraps at 32.
// R14 - After a wrap, a later byte replaces the earlier one in that slot.
// R15 - All bytes of a page session are committed in one programming cycle.
// R16 - Master polls by repeating its request until acknowledged.
// R17 - Write protect sampled at last clock fall before first data byte.
// R18 - Protect high: first data byte not acknowledged, whole write rejected.
// R19 - Memory starts filled with the erased value.
// R20 - Read without address load returns the byte at the current address.
// R21 - Master ends a read with no acknowledge then stop; slave goes standby.
// R22 - Selective read: write address bytes, repeated start, read address byte.
// R23 - Slave keeps sending while the master acknowledges each byte.
// R24 - Sequential reads increment across all memory and wrap to zero.
// R25 - 4096 bytes, 12-bit address; address ends after the last byte accessed.
// R26 - Programming busy lasts a configurable cycle count; addresses not acknowledged.
package sep_pkg;
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          PROG_TIME_MS  = 5;
  localparam int          PROG_CYCLES   = PROG_TIME_MS * (CLK_HZ / 1000);
  localparam int          MEM_AW        = 12;
  localparam int          PAGE_AW       = 5;
  localparam int          PAGE_BYTES    = 32;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_W        = PAGE_AW + 8;
  localparam logic [7:0]  ERASED        = 8'hff;
  // pin vector positions after synchronising
  localparam int          PIN_SCL       = 0;
  localparam int          PIN_SDA       = 1;
  localparam int          PIN_WP        = 2;
  localparam int          PIN_SEL0      = 3;
  localparam logic [5:0]  PIN_RST       = 6'h03;
  localparam logic [3:0]  BIT_LAST      = 4'h8;
  localparam logic [3:0]  TX_LAST       = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_RACK = 3'b010,
    ST_TX   = 3'b011,
    ST_TACK = 3'b100
  } sep_state_t;

  typedef enum logic [1:0] {
    BK_DEV  = 2'b00,
    BK_AHI  = 2'b01,
    BK_ALO  = 2'b10,
    BK_DATA = 2'b11
  } sep_kind_t;
endpackage

// File: src/sep_fifo.sv
`timescale 1ns/1ps
module sep_fifo
  import sep_pkg::*;
#(
  parameter int W = FIFO_W,
  parameter int D = FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D || W < 1) begin : g_chk
    $error("sep_fifo: depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } sep_fifo_t;

  sep_fifo_t   r;
  sep_fifo_t   n;
  logic [W-1:0] mem [D];
  logic        push;
  logic        pop;

  assign in_ready  = (r.cnt != (AW+1)'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data  = mem[r.rp];
  assign push      = en & in_valid & in_ready;
  assign pop       = en & out_valid & out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[r.wp] <= in_data;
    end
  end
endmodule // sep_fifo

// File: verif/sep_master.sv
`timescale 1ns/1ps
module sep_master (
  // clock
  input  wire logic ref_clk,
  // bus lines
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda_line
);
  // idle bus: both released high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask

  // data moves only with the clock low
  task automatic bitx(input logic b, output logic r);
    sda_m <= b;
    half();
    scl <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) r = sda_line;
    @(posedge ref_clk);
    scl <= 1'b0;
  endtask

  // also serves as repeated start
  task automatic start();
    sda_m <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    scl <= 1'b0;
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask

  task automatic wr(input logic [7:0] dat, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(dat[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd(input logic ack, output logic [7:0] dat);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, dat[i]);
    end
    bitx(~ack, r);
  endtask
endmodule // sep_master

// File: verif/sep_eeprom_slave_tb.sv
`timescale 1ns/1ps
module sep_eeprom_slave_tb;
  import sep_pkg::*;
  localparam int PCYC  = 100;
  localparam int LIMIT = 30000;
  typedef struct packed {
    logic [7:0] dev;
    logic       ack;
    logic [7:0] data;
  } sep_row_t;
  // straps are 3'b101, type code 4'h5
  localparam sep_row_t ROWS [6] = '{'{8'h5a, 1'b1, 8'hff}, '{8'h5b, 1'b1, 8'hff},
    '{8'h58, 1'b0, 8'hff}, '{8'h4a, 1'b0, 8'hff}, '{8'h5f, 1'b0, 8'hff},
    '{8'h5b, 1'b1, 8'hff}};

  logic       ref_clk;
  logic       rst;
  logic       ce;
  logic       wp;
  logic [2:0] sel;
  logic       scl;
  logic       sda_m;
  logic       sda_line;
  logic       sda_o;
  logic       sda_oe_n;
  logic       prog_busy;
  logic       k;
  logic [7:0] d;
  int         fail_count;
  int         check_count;
  int         cyc;
  int         busy_cnt;
  logic [7:0] exp_mem [4096];

  // open-drain wire with pull-up
  assign sda_line = sda_m & (sda_oe_n | sda_o);

  sep_eeprom_slave #(.PROG_CYC(PCYC), .HAS_STRAPS(1'b1), .DEV_TYPE(4'h5)) i_sep_eeprom_slave (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
    .addr_select_bit2(sel[2]), .wp(wp), .prog_busy(prog_busy));

  sep_master i_sep_master (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda_line(sda_line));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    busy_cnt <= busy_cnt + int'(prog_busy);
    if (cyc == LIMIT) begin
      fail_count++;
      $display("timeout after %0d cycles", cyc);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_num(input string what, input int e, input int g);
    check_count++;
    if (g != e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic set_addr(input logic [11:0] a);
    logic ak;
    i_sep_master.start();
    i_sep_master.wr(8'h5a, ak);
    chk_bit("dev ack", 1'b1, ak);
    i_sep_master.wr({4'h0, a[11:8]}, ak);
    chk_bit("addr hi ack", 1'b1, ak);
    i_sep_master.wr(a[7:0], ak);
    chk_bit("addr lo ack", 1'b1, ak);
  endtask

  task automatic rd_at(input logic [11:0] a, input int n);
    logic       ak;
    logic [7:0] v;
    set_addr(a);
    i_sep_master.start();
    i_sep_master.wr(8'h5b, ak);
    chk_bit("read dev ack", 1'b1, ak);
    for (int i = 0; i < n; i++) begin
      i_sep_master.rd(i < n - 1, v);
      chk_byte("read data", exp_mem[12'(a + i)], v);
    end
    i_sep_master.stop();
  endtask

  // ok low means the data is expected to be refused
  task automatic page_wr(input logic [11:0] a, input int n, input logic [7:0] seed,
                         input logic ok);
    logic ak;
    int   b0;
    int   polls;
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      i_sep_master.wr(seed + 8'(i), ak);
      chk_bit("data ack", ok, ak);
      if (ok) exp_mem[{a[11:5], 5'(a[4:0] + i)}] = seed + 8'(i);
    end
    b0 = busy_cnt;
    i_sep_master.stop();
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit("busy after stop", ok, prog_busy);
    ak = 1'b0;
    polls = 0;
    while (!ak && polls < 20) begin
      i_sep_master.start();
      i_sep_master.wr(8'h5a, ak);
      i_sep_master.stop();
      polls++;
    end
    chk_bit("poll ack", 1'b1, ak);
    chk_bit("poll refused", ok, polls > 1);
    chk_num("busy cycles", ok ? PCYC : 0, busy_cnt - b0);
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wp = 1'b0;
    sel = 3'b101;
    foreach (exp_mem[i]) exp_mem[i] = 8'hff;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit("idle release", 1'b1, sda_oe_n);
    chk_bit("idle busy", 1'b0, prog_busy);
    $display("test reset done");
    @(posedge ref_clk);
    foreach (ROWS[i]) begin
      i_sep_master.start();
      i_sep_master.wr(ROWS[i].dev, k);
      chk_bit("dev ack", ROWS[i].ack, k);
      if (k & ROWS[i].dev[0]) begin
        i_sep_master.rd(1'b0, d);
        chk_byte("immediate read", ROWS[i].data, d);
      end
      i_sep_master.stop();
      @(negedge ref_clk);
      chk_bit("no program", 1'b0, prog_busy);
      $display("test row %0d done", i);
      @(posedge ref_clk);
    end
    page_wr(12'h13e, 34, 8'h00, 1'b1);
    rd_at(12'h11f, 4);
    rd_at(12'h13e, 3);
    $display("test page wrap done");
    wp <= 1'b1;
    page_wr(12'h010, 1, 8'h55, 1'b0);
    wp <= 1'b0;
    rd_at(12'h010, 1);
    $display("test protect done");
    page_wr(12'h000, 2, 8'h35, 1'b1);
    rd_at(12'hfff, 2);
    i_sep_master.start();
    i_sep_master.wr(8'h5b, k);
    i_sep_master.rd(1'b0, d);
    i_sep_master.stop();
    chk_byte("current address", exp_mem[1], d);
    chk_bit("current dev ack", 1'b1, k);
    $display("test address wrap done");
    set_addr(12'h040);
    i_sep_master.wr(8'h77, k);
    chk_bit("freeze data ack", 1'b1, k);
    i_sep_master.stop();
    exp_mem[12'h040] = 8'h77;
    repeat (2) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (150) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit("frozen busy", 1'b1, prog_busy);
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (110) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit("busy resumed", 1'b0, prog_busy);
    @(posedge ref_clk);
    rd_at(12'h040, 1);
    $display("test freeze done");
    set_addr(12'h000);
    i_sep_master.start();
    i_sep_master.wr(8'h5b, k);
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit("read drive", 1'b0, sda_oe_n);
    chk_bit("read low", 1'b0, sda_o);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_bit("reset release", 1'b1, sda_oe_n);
    @(posedge ref_clk);
    i_sep_master.stop();
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    i_sep_master.start();
    i_sep_master.wr(8'h5b, k);
    chk_bit("ack after reset", 1'b1, k);
    i_sep_master.rd(1'b0, d);
    i_sep_master.stop();
    chk_byte("read after reset", exp_mem[0], d);
    $display("test reset midrun done");
    complete_run();
  end
endmodule // sep_eeprom_slave_tb
